// file: design/otcs_defs.svh
// Constants for the packet-tail and repetition sequencer.
// Assumes it is included by bare name from design and testbench files.
`ifndef OTCS_DEFS_SVH
`define OTCS_DEFS_SVH

`define OTCS_ADDR_FEATURES 8'h08
`define OTCS_ADDR_GROUPS 8'h09
`define OTCS_ADDR_STOP_LEN 8'h15
`define OTCS_ADDR_STOP_LOW 8'h22
`define OTCS_ADDR_STOP_HIGH 8'h23
`define OTCS_ADDR_PAUSE_LEN 8'h24
`define OTCS_ADDR_PACKETS 8'h25
`define OTCS_ADDR_STATUS 8'h27

`define OTCS_BIT_PRE_LOC 2
`define OTCS_BIT_STOP_EN 5
`define OTCS_BIT_GAP_EN 6
`define OTCS_BIT_CYCLE_EN 7

`define OTCS_REG_RESET 8'h00
`define OTCS_COUNT_ZERO 8'h00
`define OTCS_STOP_ZERO 4'h0
`define OTCS_STOP_MSB 4'hf
`define OTCS_SYM_ZERO 1'b0

`define OTCS_FIFO_WIDTH 1
`define OTCS_FIFO_DEPTH 8
`define OTCS_LEVEL_ROOM 4'h7

`endif

// file: design/otcs_pkg.sv
// Types shared by the sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package otcs_pkg;

  typedef enum logic [2:0] {
    OTCS_IDLE = 3'b000,
    OTCS_CAL = 3'b001,
    OTCS_PRE = 3'b010,
    OTCS_BODY = 3'b011,
    OTCS_STOP = 3'b100,
    OTCS_GAP = 3'b101
  } otcs_state_t;

endpackage : otcs_pkg

// file: design/otcs_fifo.sv
// Symbol FIFO with valid and ready on both sides and a fill level.
// Assumes DEPTH is a power of two and one clock for both sides.
`timescale 1ns/1ns
`default_nettype none
module otcs_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Filling side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Draining side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady,
  // Occupancy
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  logic push;
  logic pop;

  assign level = wrPtr - rdPtr;
  assign inReady = (level != (AW+1)'(DEPTH));
  assign outValid = (level != '0);
  assign outData = store[rdPtr[AW-1:0]];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      store[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop)
      begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end

endmodule : otcs_fifo
`default_nettype wire

// file: design/ook_packet_tail_cycle_sequencer.sv
// Packet-tail and repetition sequencer of the on-off-keyed transmitter.
// Assumes same-clock field sources and a calDone pulse from calibration.
`timescale 1ns/1ns
`default_nettype none
`include "otcs_defs.svh"

// Behaviour
// RQ1: Supply level measured once, right after calibration.
// RQ2: Host goes standby then transmit for fresh reading.
// RQ3: Feature bit five enables stop symbols.
// RQ4: Stop disabled means no stop symbols.
// RQ5: Stop symbol count is length field plus one.
// RQ6: Pattern uses upper byte, both for long lengths.
// RQ7: Stop pattern sent from bit fifteen downward.
// RQ8: Feature bit six enables pause interval.
// RQ9: Interval length is field value plus one.
// RQ10: Interval symbols are all logic zero.
// RQ11: Body fields precede the stop symbols.
// RQ12: Cycle holds groups of repeated packets, pauses between.
// RQ13: Feature bit seven enables repetition, else single packet.
// RQ14: Bit two places preamble: each packet or first.
// RQ15: Group count is register value plus one.
// RQ16: Packets per group is register value plus one.
// RQ17: Preamble disabled means no preamble anywhere.
// RQ18: Host clears placement and groups without repetition.
// RQ19: Cycle ends after last packet of last group.
module ook_packet_tail_cycle_sequencer
  import otcs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Transmission control
  input wire logic txStart,
  input wire logic calDone,
  input wire logic preambleEnable,
  output logic supplyLevelCheck,
  output logic cycleActive,
  output logic cycleDone,
  // Preamble stream
  input wire logic preValid,
  input wire logic preSymbol,
  input wire logic preLast,
  output logic preReady,
  // Body stream: sync, address, key and battery fields in that order
  input wire logic bodyValid,
  input wire logic bodySymbol,
  input wire logic bodyLast,
  output logic bodyReady,
  // Symbol output
  output logic outValid,
  output logic outSymbol,
  input wire logic outReady
);

  logic [7:0] packetFeatureEnables, cycleGroupCount, stopSymbolLength;
  logic [7:0] stopPatternLow, stopPatternHigh, pauseSymbolLength;
  logic [7:0] packetsPerGroup;

  otcs_state_t state, next_state;
  logic [7:0] pktIdx, grpIdx, next_pktIdx, next_grpIdx, gapIdx;
  logic stopEn, gapEn, cycleEn, preLoc;
  logic [15:0] stopPattern;
  logic [3:0] stopIdx, stopLen;

  logic fifoInValid, fifoInData, fifoInReady;
  logic fifoOutValid, fifoOutData, fifoOutReady;
  logic [3:0] fifoLevel;
  logic pushPre, pushBody, pushStop, pushGap;
  logic endBody, stopEnd, gapEnd, pktFinish, lastPkt;

  function automatic logic addrHit(input logic [7:0] addr,
                                   input logic [7:0] offset);
    addrHit = (addr == offset);
  endfunction : addrHit

  // Preamble ahead of a packet, given that packet's index in its group.
  function automatic otcs_state_t packetStart(input logic [7:0] idx,
    input logic preOn, input logic repeatOn, input logic firstOnly);
    packetStart = (preOn && (!repeatOn || !firstOnly ||
      idx == `OTCS_COUNT_ZERO)) ? OTCS_PRE : OTCS_BODY;
  endfunction : packetStart

  assign stopEn = packetFeatureEnables[`OTCS_BIT_STOP_EN]; // RQ3
  assign gapEn = packetFeatureEnables[`OTCS_BIT_GAP_EN]; // RQ8
  assign cycleEn = packetFeatureEnables[`OTCS_BIT_CYCLE_EN]; // RQ13
  assign preLoc = packetFeatureEnables[`OTCS_BIT_PRE_LOC]; // RQ14
  assign stopPattern = {stopPatternHigh, stopPatternLow}; // RQ6
  assign stopLen = stopSymbolLength[3:0]; // RQ5

  // Register writes; the host owns every field.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      packetFeatureEnables <= `OTCS_REG_RESET;
      cycleGroupCount <= `OTCS_REG_RESET;
      stopSymbolLength <= `OTCS_REG_RESET;
      stopPatternLow <= `OTCS_REG_RESET;
      stopPatternHigh <= `OTCS_REG_RESET;
      pauseSymbolLength <= `OTCS_REG_RESET;
      packetsPerGroup <= `OTCS_REG_RESET;
    end
    else if (regWrite)
    begin
      if (addrHit(regAddr, `OTCS_ADDR_FEATURES))
        packetFeatureEnables <= regWdata;
      if (addrHit(regAddr, `OTCS_ADDR_GROUPS))
        cycleGroupCount <= regWdata;
      if (addrHit(regAddr, `OTCS_ADDR_STOP_LEN))
        stopSymbolLength <= regWdata;
      if (addrHit(regAddr, `OTCS_ADDR_STOP_LOW))
        stopPatternLow <= regWdata;
      if (addrHit(regAddr, `OTCS_ADDR_STOP_HIGH))
        stopPatternHigh <= regWdata;
      if (addrHit(regAddr, `OTCS_ADDR_PAUSE_LEN))
        pauseSymbolLength <= regWdata;
      if (addrHit(regAddr, `OTCS_ADDR_PACKETS))
        packetsPerGroup <= regWdata;
    end
  end

  // Read data is held until the next read; unmapped addresses read zero.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdata <= `OTCS_REG_RESET;
    else if (regRead)
    begin
      if (addrHit(regAddr, `OTCS_ADDR_FEATURES))
        regRdata <= packetFeatureEnables;
      else if (addrHit(regAddr, `OTCS_ADDR_GROUPS))
        regRdata <= cycleGroupCount;
      else if (addrHit(regAddr, `OTCS_ADDR_STOP_LEN))
        regRdata <= stopSymbolLength;
      else if (addrHit(regAddr, `OTCS_ADDR_STOP_LOW))
        regRdata <= stopPatternLow;
      else if (addrHit(regAddr, `OTCS_ADDR_STOP_HIGH))
        regRdata <= stopPatternHigh;
      else if (addrHit(regAddr, `OTCS_ADDR_PAUSE_LEN))
        regRdata <= pauseSymbolLength;
      else if (addrHit(regAddr, `OTCS_ADDR_PACKETS))
        regRdata <= packetsPerGroup;
      else if (addrHit(regAddr, `OTCS_ADDR_STATUS))
        regRdata <= {cycleActive, 4'h0, state};
      else
        regRdata <= `OTCS_REG_RESET;
    end
  end

  // Symbol pushes into the FIFO from each phase.
  assign pushPre = (state == OTCS_PRE) && preReady && preValid;
  assign pushBody = (state == OTCS_BODY) && bodyReady && bodyValid; // RQ11
  assign pushStop = (state == OTCS_STOP) && fifoInReady;
  assign pushGap = (state == OTCS_GAP) && fifoInReady;
  assign endBody = pushBody && bodyLast;
  assign stopEnd = pushStop && (stopIdx == stopLen); // RQ5
  assign gapEnd = pushGap && (gapIdx == pauseSymbolLength); // RQ9
  assign pktFinish = (endBody && !stopEn) || stopEnd; // RQ4
  assign lastPkt = !cycleEn || // RQ13
    (pktIdx == packetsPerGroup && grpIdx == cycleGroupCount); // RQ19

  always_comb
  begin
    fifoInValid = pushPre || pushBody || pushStop || pushGap;
    fifoInData = `OTCS_SYM_ZERO; // RQ10
    if (pushPre)
      fifoInData = preSymbol;
    else if (pushBody)
      fifoInData = bodySymbol;
    else if (pushStop)
      fifoInData = stopPattern[`OTCS_STOP_MSB - stopIdx]; // RQ7
  end

  // Index of the packet that follows the one now finishing.
  always_comb
  begin
    next_pktIdx = pktIdx + 8'h01;
    next_grpIdx = grpIdx;
    if (pktIdx == packetsPerGroup) // RQ16
    begin
      next_pktIdx = `OTCS_COUNT_ZERO;
      next_grpIdx = grpIdx + 8'h01; // RQ15
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      OTCS_IDLE:
        if (txStart)
          next_state = OTCS_CAL;
      OTCS_CAL:
        if (calDone)
          next_state = packetStart(`OTCS_COUNT_ZERO, preambleEnable,
                                   cycleEn, preLoc); // RQ17
      OTCS_PRE:
        if (pushPre && preLast)
          next_state = OTCS_BODY;
      OTCS_BODY:
        if (endBody)
          next_state = stopEn ? OTCS_STOP : OTCS_BODY; // RQ3
      OTCS_STOP:
        next_state = OTCS_STOP;
      OTCS_GAP:
        if (gapEnd)
          next_state = packetStart(pktIdx, preambleEnable, cycleEn,
                                   preLoc); // RQ14
      default:
        next_state = OTCS_IDLE;
    endcase
    if (pktFinish)
    begin
      if (lastPkt)
        next_state = OTCS_IDLE; // RQ19
      else if (gapEn)
        next_state = OTCS_GAP; // RQ12
      else
        next_state = packetStart(next_pktIdx, preambleEnable, cycleEn,
                                 preLoc); // RQ14
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= OTCS_IDLE;
    else
      state <= next_state;
  end

  // Packet and group counters advance as each packet but the last finishes.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pktIdx <= `OTCS_COUNT_ZERO;
      grpIdx <= `OTCS_COUNT_ZERO;
    end
    else if (state == OTCS_CAL)
    begin
      pktIdx <= `OTCS_COUNT_ZERO;
      grpIdx <= `OTCS_COUNT_ZERO;
    end
    else if (pktFinish && !lastPkt)
    begin
      pktIdx <= next_pktIdx; // RQ16
      grpIdx <= next_grpIdx; // RQ15
    end
  end

  // Stop and interval symbol counters restart on entry to their phase.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stopIdx <= `OTCS_STOP_ZERO;
      gapIdx <= `OTCS_COUNT_ZERO;
    end
    else
    begin
      if (state != OTCS_STOP)
        stopIdx <= `OTCS_STOP_ZERO;
      else if (pushStop)
        stopIdx <= stopIdx + 4'h1; // RQ5
      if (state != OTCS_GAP)
        gapIdx <= `OTCS_COUNT_ZERO;
      else if (pushGap)
        gapIdx <= gapIdx + 8'h01; // RQ9
    end
  end

  // Ready is registered, so it keeps one FIFO slot spare for a late push.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      preReady <= 1'b0;
      bodyReady <= 1'b0;
    end
    else
    begin
      preReady <= (next_state == OTCS_PRE) && (fifoLevel < `OTCS_LEVEL_ROOM);
      bodyReady <= (next_state == OTCS_BODY) &&
        (fifoLevel < `OTCS_LEVEL_ROOM);
    end
  end

  // One measurement strobe per transmission start, never repeated.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      supplyLevelCheck <= 1'b0;
      cycleDone <= 1'b0;
      cycleActive <= 1'b0;
    end
    else
    begin
      supplyLevelCheck <= (state == OTCS_CAL) && calDone; // RQ1
      cycleDone <= pktFinish && lastPkt; // RQ19
      cycleActive <= (next_state != OTCS_IDLE);
    end
  end

  otcs_fifo #(.WIDTH(`OTCS_FIFO_WIDTH), .DEPTH(`OTCS_FIFO_DEPTH)) symbolFifo (
    .ref_clk(ref_clk), .reset_n(reset_n), .inValid(fifoInValid),
    .inData(fifoInData), .inReady(fifoInReady), .outValid(fifoOutValid),
    .outData(fifoOutData), .outReady(fifoOutReady), .level(fifoLevel));

  // Output register; a modulator stall backs up through the FIFO.
  assign fifoOutReady = !outValid || outReady;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      outValid <= 1'b0;
      outSymbol <= `OTCS_SYM_ZERO;
    end
    else if (fifoOutReady)
    begin
      outValid <= fifoOutValid;
      outSymbol <= fifoOutData;
    end
  end

  default clocking assertClk @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_supply_once: assert property (supplyLevelCheck |-> // RQ1
    $past(calDone) && !$past(supplyLevelCheck) && state != OTCS_CAL)
    else $error("supply check not after calibration");
  a_stop_gated: assert property (endBody && !stopEn |=> // RQ4
    state != OTCS_STOP) else $error("stop symbols sent while disabled");
  a_stop_count: assert property (pushStop && stopIdx == stopLen |=> // RQ5
    state != OTCS_STOP) else $error("stop run longer than length plus one");
  a_stop_msb_first: assert property (pushStop && // RQ7
    stopIdx == `OTCS_STOP_ZERO |-> fifoInData == stopPattern[`OTCS_STOP_MSB])
    else $error("stop pattern not sent from top bit");
  a_gap_zero: assert property (pushGap |-> fifoInValid && // RQ10
    fifoInData == `OTCS_SYM_ZERO) else $error("interval symbol not zero");
  a_gap_gated: assert property (pktFinish && !gapEn |=> // RQ8
    state != OTCS_GAP) else $error("interval sent while disabled");
  a_gap_length: assert property (pushGap && // RQ9
    gapIdx == pauseSymbolLength |=> state != OTCS_GAP)
    else $error("interval longer than length plus one");
  a_no_preamble: assert property (state != OTCS_PRE && // RQ17
    next_state == OTCS_PRE |-> preambleEnable)
    else $error("preamble entered while disabled");
  a_single_packet: assert property (pktFinish && !cycleEn |=> // RQ13
    state == OTCS_IDLE && cycleDone)
    else $error("single packet did not end cycle");
  a_pre_first_only: assert property (pktFinish && !lastPkt && // RQ14
    cycleEn && preLoc && !gapEn && next_pktIdx != `OTCS_COUNT_ZERO |=>
    state == OTCS_BODY) else $error("preamble repeated inside group");
  a_cycle_end: assert property (cycleDone |-> state == OTCS_IDLE && // RQ19
    $past(pktFinish) && !cycleActive)
    else $error("cycle end without last packet");

endmodule : ook_packet_tail_cycle_sequencer
`default_nettype wire

// file: testbench/otcs_stream_partner.sv
// Far-side model: preamble and body field sources and the modulator sink.
// Assumes the sequencer samples every handshake on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module otcs_stream_partner #(
  parameter int PRE_LEN = 3,
  parameter int BODY_LEN = 5,
  parameter logic [7:0] BODY_BITS = 8'h1a
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Field sources
  output logic preValid,
  output logic preSymbol,
  output logic preLast,
  input wire logic preReady,
  output logic bodyValid,
  output logic bodySymbol,
  output logic bodyLast,
  input wire logic bodyReady,
  // Modulator sink
  input wire logic outValid,
  input wire logic outSymbol,
  output logic outReady,
  input wire logic slowSink
);
  int preIdx;
  int bodyIdx;
  logic stallPhase;

  // The field generators always offer their next symbol and hold it until
  // the sequencer takes it, so a late ready never loses a symbol.
  assign preValid = 1'b1;
  assign preSymbol = ~preIdx[0];
  assign preLast = (preIdx == PRE_LEN - 1);
  assign bodyValid = 1'b1;
  assign bodySymbol = BODY_BITS[BODY_LEN - 1 - bodyIdx];
  assign bodyLast = (bodyIdx == BODY_LEN - 1);
  // A slow modulator takes a symbol only on every other cycle.
  assign outReady = ~slowSink | stallPhase;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      preIdx <= 0;
      bodyIdx <= 0;
      stallPhase <= 1'b0;
    end
    else
    begin
      stallPhase <= ~stallPhase;
      if (preValid && preReady)
        preIdx <= preLast ? 0 : preIdx + 1;
      if (bodyValid && bodyReady)
        bodyIdx <= bodyLast ? 0 : bodyIdx + 1;
    end
  end
endmodule : otcs_stream_partner
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the packet-tail and repetition sequencer.
// Assumes the stream partner model serves the field and modulator sides.
`timescale 1ns/1ns
`default_nettype none
`include "otcs_defs.svh"
module testbench;
  localparam int PRE_LEN = 3;
  localparam int BODY_LEN = 5;
  localparam logic [7:0] BODY_BITS = 8'h1a;
  localparam int LIMIT = 40000;

  typedef struct {
    logic [7:0] feat;
    logic [7:0] groups;
    logic [7:0] stopLen;
    logic [15:0] pat;
    logic [7:0] gapLen;
    logic [7:0] packets;
    logic pre;
    logic slow;
  } otcs_case_t;

  logic ref_clk, reset_n, regWrite, regRead, txStart, calDone;
  logic [7:0] regAddr, regWdata, regRdata;
  logic preambleEnable, supplyLevelCheck, cycleActive, cycleDone;
  logic preValid, preSymbol, preLast, preReady;
  logic bodyValid, bodySymbol, bodyLast, bodyReady;
  logic outValid, outSymbol, outReady, slowSink;
  logic got[$];
  logic expSym[$];
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  int nCheck = 0;
  int nDone = 0;
  otcs_case_t cases[6];
  logic [7:0] addrs[7] = '{`OTCS_ADDR_FEATURES, `OTCS_ADDR_GROUPS,
    `OTCS_ADDR_STOP_LEN, `OTCS_ADDR_STOP_LOW, `OTCS_ADDR_STOP_HIGH,
    `OTCS_ADDR_PAUSE_LEN, `OTCS_ADDR_PACKETS};

  ook_packet_tail_cycle_sequencer ook_packet_tail_cycle_sequencer_inst (
    .ref_clk, .reset_n, .regWrite, .regRead, .regAddr, .regWdata,
    .regRdata, .txStart, .calDone, .preambleEnable, .supplyLevelCheck,
    .cycleActive, .cycleDone, .preValid, .preSymbol, .preLast, .preReady,
    .bodyValid, .bodySymbol, .bodyLast, .bodyReady, .outValid, .outSymbol,
    .outReady);

  otcs_stream_partner #(.PRE_LEN(PRE_LEN), .BODY_LEN(BODY_LEN),
    .BODY_BITS(BODY_BITS)) otcs_stream_partner_inst (
    .ref_clk, .reset_n, .preValid, .preSymbol, .preLast, .preReady,
    .bodyValid, .bodySymbol, .bodyLast, .bodyReady, .outValid, .outSymbol,
    .outReady, .slowSink);

  always #10 ref_clk = ~ref_clk;

  always @(negedge ref_clk)
  begin
    cycles++;
    if (supplyLevelCheck === 1'b1)
      nCheck++;
    if (cycleDone === 1'b1)
      nDone++;
    if (outValid === 1'b1 && outReady === 1'b1)
      got.push_back(outSymbol);
    if (cycles == LIMIT)
    begin
      n_mismatch++;
      results();
    end
  end

  task automatic results();
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  task automatic cmpv(input string what, input logic [7:0] e,
    input logic [7:0] s);
    checks_done++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : cmpv

  task automatic cmpn(input string what, input int e, input int s);
    checks_done++;
    if (s != e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %0d seen %0d", what, e, s);
    end
  endtask : cmpn

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge ref_clk);
    regWrite = 1'b0;
  endtask : reg_write

  task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge ref_clk);
    regRead = 1'b0;
    @(negedge ref_clk);
    cmpv($sformatf("register %h", a), e, regRdata);
  endtask : check_reg

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask : pulse

  // Preamble with placement 1 leads the first packet of every group.
  task automatic build(input otcs_case_t c);
    int groups;
    int packets;
    logic cyc;
    cyc = c.feat[`OTCS_BIT_CYCLE_EN];
    groups = cyc ? c.groups + 1 : 1;
    packets = cyc ? c.packets + 1 : 1;
    expSym.delete();
    for (int g = 0; g < groups; g++)
      for (int p = 0; p < packets; p++)
      begin
        if (c.pre && (!cyc || !c.feat[`OTCS_BIT_PRE_LOC] || p == 0))
          for (int i = 0; i < PRE_LEN; i++)
            expSym.push_back(i % 2 == 0);
        for (int i = 0; i < BODY_LEN; i++)
          expSym.push_back(BODY_BITS[BODY_LEN - 1 - i]);
        if (c.feat[`OTCS_BIT_STOP_EN])
          for (int i = 0; i <= c.stopLen[3:0]; i++)
            expSym.push_back(c.pat[15 - i]);
        if (c.feat[`OTCS_BIT_GAP_EN] && (g < groups - 1 || p < packets - 1))
          for (int i = 0; i <= c.gapLen; i++)
            expSym.push_back(1'b0);
      end
  endtask : build

  task automatic run_case(input otcs_case_t c);
    logic [7:0] vals[7];
    int n;
    vals = '{c.feat, c.groups, c.stopLen, c.pat[7:0], c.pat[15:8],
      c.gapLen, c.packets};
    for (int i = 0; i < 7; i++)
      reg_write(addrs[i], vals[i]);
    for (int i = 0; i < 7; i++)
      check_reg(addrs[i], vals[i]);
    build(c);
    preambleEnable = c.pre;
    slowSink = c.slow;
    got.delete();
    n = nCheck;
    pulse(calDone);
    repeat (3) @(negedge ref_clk);
    cmpn("early supply checks", n, nCheck);
    nDone = 0;
    pulse(txStart);
    check_reg(`OTCS_ADDR_STATUS, 8'h81);
    pulse(txStart);
    pulse(calDone);
    for (int t = 0; t < 4000 && cycleDone !== 1'b1; t++)
      @(negedge ref_clk);
    repeat (40) @(negedge ref_clk);
    cmpn("supply checks", n + 1, nCheck);
    cmpn("cycle ends", 1, nDone);
    cmpn("symbol count", expSym.size(), got.size());
    for (int i = 0; i < expSym.size() && i < got.size(); i++)
      cmpv("symbol", {7'h00, expSym[i]}, {7'h00, got[i]});
    check_reg(`OTCS_ADDR_STATUS, 8'h00);
  endtask : run_case

  initial
  begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    txStart = 1'b0;
    calDone = 1'b0;
    preambleEnable = 1'b0;
    slowSink = 1'b0;
    cases[0] = '{8'h20, 8'h00, 8'h07, 16'h5600, 8'h03, 8'h02, 1'b1, 1'b0};
    cases[1] = '{8'h40, 8'h00, 8'h0f, 16'hffff, 8'h05, 8'h00, 1'b0, 1'b1};
    cases[2] = '{8'he0, 8'h01, 8'h0f, 16'ha5c3, 8'h02, 8'h02, 1'b1, 1'b1};
    cases[3] = '{8'hc4, 8'h01, 8'h00, 16'h8000, 8'h00, 8'h01, 1'b1, 1'b0};
    cases[4] = '{8'ha4, 8'h00, 8'h03, 16'h9000, 8'hff, 8'h01, 1'b1, 1'b0};
    cases[5] = '{8'hc4, 8'h00, 8'h00, 16'h0000, 8'hff, 8'h01, 1'b0, 1'b0};
    repeat (10) @(negedge ref_clk);
    reset_n = 1'b1;
    for (int i = 0; i < 7; i++)
      check_reg(addrs[i], `OTCS_REG_RESET);
    check_reg(`OTCS_ADDR_STATUS, 8'h00);
    reg_write(8'h30, 8'h5a);
    check_reg(8'h30, 8'h00);
    for (int i = 0; i < 6; i++)
      run_case(cases[i]);
    results();
  end
endmodule : testbench
`default_nettype wire
